// *** eeprom_pkg.sv ***
// Purpose: shared constants and types of the serial eeprom program control
// Assumes: three-wire serial link, self-timed nonvolatile cycle
// Notes:   field values follow the instruction frame layout
`default_nettype none
package eeprom_pkg;
	localparam int START_BITS = 1;
	localparam int OP_BITS    = 2;
	localparam int LEAD_BITS  = 2;
	localparam int HDR_BITS   = START_BITS + OP_BITS;
	localparam int BYTE_BITS  = 8;
	localparam int WORD_BITS  = 16;
	localparam int CNT_W      = 6;
	localparam int TMR_W      = 16;
	localparam int SYNC_W     = 4;

	// sync vector bit positions
	localparam int SY_SDI  = 0;
	localparam int SY_SCLK = 1;
	localparam int SY_CS   = 2;
	localparam int SY_ORG  = 3;

	localparam logic [1:0] OP_EXT   = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_ERASE = 2'h3;

	// leading address bits under OP_EXT
	localparam logic [1:0] EXT_DIS   = 2'h0;
	localparam logic [1:0] EXT_WRITE_WHOLE_ARRAY  = 2'h1;
	localparam logic [1:0] EXT_ERASE_WHOLE_ARRAY  = 2'h2;
	localparam logic [1:0] EXT_EN    = 2'h3;

	localparam logic [7:0]  ERASED_BYTE = 8'hFF;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;

	localparam int CLK_NS                = 5;
	localparam int STATUS_VALID_DELAY_NS = 250;
	localparam int WRITE_CYCLE_NS        = 5000;

	typedef logic [CNT_W-1:0] cnt_t;
	typedef logic [TMR_W-1:0] tmr_t;
	typedef logic [SYNC_W-1:0] sync_t;

	typedef enum {EX_IDLE, EX_ERASE, EX_PROG, EX_HOLD} ex_state_t;

	// value to store and how bytes pair into it
	typedef struct packed {
		logic [WORD_BITS-1:0] value;
		logic                 word;
	} cyc_t;
endpackage
`default_nettype wire

// *** serial_eeprom_program_erase_ctrl.sv ***
// Purpose: program/erase control of a three-wire serial eeprom
// Assumes: pins are asynchronous to CLK and pass two flops
// Notes:   read path is not part of this block
//
// Contract
// - single erase sets every bit of addressed byte or word to one
// - erase starts self-timed cycle at chip select fall after valid address
// - data input sampled on every rising serial clock edge; code samples it only while chip select is high and no cycle is busy
// - chip select falling early or late launches nothing, memory unchanged
// - launched cycle is self-timed, independent of serial clock
// - every write is preceded by automatic erase of the target
// - erase-all takes dummy address, sets every bit to one
// - write-all takes dummy address and data, stores data everywhere
// - busy cycle drives output low while chip select high, after delay
// - data input ignored while busy
// - cycle done and chip select high drives output high
// - ready level held until chip select low or start bit decoded
// - array starts as all ones
// - clock pulses counted from start bit to chip select fall
// - wrong pulse count aborts modifying instruction, memory untouched
// - expected count is start plus two opcode plus address plus data bits
// - modifying instructions disabled at reset until enable instruction
// - write-all coded start one, opcode 00, leading address 01
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_program_erase_ctrl #(
	parameter int ADDR_W         = 9,
	parameter int WRITE_CYCLE_NS = eeprom_pkg::WRITE_CYCLE_NS
) (
	input  wire logic CLK,
	input  wire logic NRST,
	input  wire logic CS,
	input  wire logic SCLK,
	input  wire logic SDI,
	input  wire logic WORD_SIZE_SELECT,
	output var  logic SDO,
	output var  logic SDO_OE
);
	localparam int SR_W = eeprom_pkg::OP_BITS + ADDR_W
		+ eeprom_pkg::WORD_BITS;
	localparam int NBYTES = 2 ** ADDR_W;
	localparam int CYC_N = (WRITE_CYCLE_NS + eeprom_pkg::CLK_NS - 1)
		/ eeprom_pkg::CLK_NS;
	localparam int DLY_N = (eeprom_pkg::STATUS_VALID_DELAY_NS
		+ eeprom_pkg::CLK_NS - 1) / eeprom_pkg::CLK_NS;
	localparam eeprom_pkg::tmr_t CYC_LAST =
		eeprom_pkg::tmr_t'((CYC_N < 1 ? 1 : CYC_N) - 1);
	localparam eeprom_pkg::cnt_t DLY_MAX =
		eeprom_pkg::cnt_t'(DLY_N < 1 ? 1 : DLY_N);
	localparam eeprom_pkg::cnt_t CNT_MAX = '1;
	localparam eeprom_pkg::cnt_t HDR_CNT =
		eeprom_pkg::cnt_t'(eeprom_pkg::HDR_BITS);
	localparam eeprom_pkg::cnt_t LEAD_CNT =
		eeprom_pkg::cnt_t'(eeprom_pkg::HDR_BITS + eeprom_pkg::LEAD_BITS);
	localparam eeprom_pkg::cnt_t AB_BYTE = eeprom_pkg::cnt_t'(ADDR_W);
	localparam eeprom_pkg::cnt_t AB_WORD = eeprom_pkg::cnt_t'(ADDR_W - 1);
	localparam eeprom_pkg::cnt_t DB_BYTE =
		eeprom_pkg::cnt_t'(eeprom_pkg::BYTE_BITS);
	localparam eeprom_pkg::cnt_t DB_WORD =
		eeprom_pkg::cnt_t'(eeprom_pkg::WORD_BITS);

	typedef logic [ADDR_W-1:0] idx_t;
	typedef logic [SR_W-1:0]   sr_t;

	// pin synchronisers
	eeprom_pkg::sync_t sy1_q;
	eeprom_pkg::sync_t sy2_q;
	eeprom_pkg::sync_t prev_q;

	// serial front end
	logic              started_q;
	logic              started_d;
	eeprom_pkg::cnt_t  cnt_q;
	eeprom_pkg::cnt_t  cnt_d;
	sr_t               sr_q;
	sr_t               sr_d;
	logic              en_q;
	logic              en_d;
	logic              rdy_q;
	logic              rdy_d;
	eeprom_pkg::cnt_t  dly_q;
	eeprom_pkg::cnt_t  dly_d;

	// self-timed cycle
	eeprom_pkg::ex_state_t st_q;
	eeprom_pkg::ex_state_t st_d;
	idx_t              idx_q;
	idx_t              idx_d;
	idx_t              lo_q;
	idx_t              hi_q;
	eeprom_pkg::cyc_t  cyc_q;
	eeprom_pkg::tmr_t  tmr_q;
	eeprom_pkg::tmr_t  tmr_d;
	logic [7:0]        mem [NBYTES];

	// decode wires
	wire logic cs       = sy2_q[eeprom_pkg::SY_CS];
	wire logic sdi      = sy2_q[eeprom_pkg::SY_SDI];
	wire logic word     = sy2_q[eeprom_pkg::SY_ORG];
	wire logic clk_rise = sy2_q[eeprom_pkg::SY_SCLK]
		& ~prev_q[eeprom_pkg::SY_SCLK];
	wire logic cs_fall  = prev_q[eeprom_pkg::SY_CS] & ~cs;
	wire logic busy     = st_q != eeprom_pkg::EX_IDLE;
	wire logic shift_en = clk_rise & cs & ~busy;
	wire logic start_det = shift_en & ~started_q & sdi;

	wire eeprom_pkg::cnt_t abits = word ? AB_WORD : AB_BYTE;
	wire eeprom_pkg::cnt_t dbits = word ? DB_WORD : DB_BYTE;
	wire logic [1:0] op_now = 2'(sr_q >> (cnt_q - HDR_CNT));
	wire logic [1:0] lead   = 2'(sr_q >> (cnt_q - LEAD_CNT));
	wire logic is_ext   = op_now == eeprom_pkg::OP_EXT;
	wire logic is_write_whole_array  = is_ext & (lead == eeprom_pkg::EXT_WRITE_WHOLE_ARRAY);
	wire logic is_erase_whole_array  = is_ext & (lead == eeprom_pkg::EXT_ERASE_WHOLE_ARRAY);
	wire logic is_en    = is_ext & (lead == eeprom_pkg::EXT_EN);
	wire logic is_dis   = is_ext & (lead == eeprom_pkg::EXT_DIS);
	wire logic is_write = op_now == eeprom_pkg::OP_WRITE;
	wire logic is_erase = op_now == eeprom_pkg::OP_ERASE;
	wire logic has_data = is_write | is_write_whole_array;
	wire logic is_whole = is_write_whole_array | is_erase_whole_array;
	wire logic is_mod   = is_write | is_erase | is_whole;

	// start + opcode + address + data, exact match or nothing
	wire eeprom_pkg::cnt_t exp_cnt = HDR_CNT + abits
		+ (has_data ? dbits : '0);
	wire logic cnt_ok = started_q & (cnt_q == exp_cnt);
	wire logic frame_ok = cs_fall & ~busy & cnt_ok;
	wire logic launch   = frame_ok & en_q & is_mod;

	wire sr_t  addr_sh  = has_data ? (sr_q >> dbits) : sr_q;
	wire idx_t addr_b   = idx_t'(addr_sh);
	wire idx_t word_lo  = {addr_b[ADDR_W-2:0], 1'b0};
	wire idx_t first_ix = is_whole ? '0 : (word ? word_lo : addr_b);
	wire idx_t last_ix  = is_whole ? '1
		: (word ? (word_lo | idx_t'(1)) : addr_b);
	wire logic [15:0] data_in = word ? sr_q[15:0]
		: {8'h00, sr_q[7:0]};
	wire logic [15:0] value_in = has_data ? data_in
		: eeprom_pkg::ERASED_WORD;

	wire logic [7:0] prog_byte = (cyc_q.word & idx_q[0])
		? cyc_q.value[15:8] : cyc_q.value[7:0];
	wire logic pass_end = idx_q == hi_q;
	wire logic tmr_done = tmr_q >= CYC_LAST;
	wire logic cyc_done = (st_q == eeprom_pkg::EX_HOLD) & tmr_done;
	wire logic stat_ok  = cs & (dly_q == DLY_MAX);

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			sy1_q  <= '0;
			sy2_q  <= '0;
			prev_q <= '0;
		end
		else
		begin
			sy1_q  <= {WORD_SIZE_SELECT, CS, SCLK, SDI};
			sy2_q  <= sy1_q;
			prev_q <= sy2_q;
		end
	end

	// serial shift and pulse count
	always_comb
	begin
		started_d = started_q;
		cnt_d     = cnt_q;
		sr_d      = sr_q;
		if (!cs)
		begin
			started_d = 1'b0;
			cnt_d     = '0;
			sr_d      = '0;
		end
		else if (start_det)
		begin
			started_d = 1'b1;
			cnt_d     = eeprom_pkg::cnt_t'(eeprom_pkg::START_BITS);
		end
		else if (shift_en & started_q)
		begin
			// saturate so an overrun never wraps back onto a legal count
			cnt_d = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 1'b1;
			sr_d  = {sr_q[SR_W-2:0], sdi};
		end
	end

	// enable latch, ready flag, status delay
	always_comb
	begin
		en_d = en_q;
		if (frame_ok & is_en)
			en_d = 1'b1;
		else if (frame_ok & is_dis)
			en_d = 1'b0;
		rdy_d = rdy_q;
		if (cyc_done)
			rdy_d = 1'b1;
		else if ((cs_fall & ~busy) | start_det)
			rdy_d = 1'b0;
		dly_d = dly_q;
		if (!cs)
			dly_d = '0;
		else if (dly_q != DLY_MAX)
			dly_d = dly_q + 1'b1;
	end

	// self-timed cycle: erase pass, program pass, hold to full time
	always_comb
	begin
		st_d  = st_q;
		idx_d = idx_q;
		tmr_d = tmr_done ? tmr_q : tmr_q + 1'b1;
		unique case (st_q)
			eeprom_pkg::EX_IDLE:
			begin
				tmr_d = '0;
				if (launch)
				begin
					st_d  = eeprom_pkg::EX_ERASE;
					idx_d = first_ix;
				end
			end
			eeprom_pkg::EX_ERASE:
			begin
				idx_d = pass_end ? lo_q : idx_q + 1'b1;
				if (pass_end)
					st_d = eeprom_pkg::EX_PROG;
			end
			eeprom_pkg::EX_PROG:
			begin
				idx_d = idx_q + 1'b1;
				if (pass_end)
					st_d = eeprom_pkg::EX_HOLD;
			end
			eeprom_pkg::EX_HOLD:
				if (tmr_done)
					st_d = eeprom_pkg::EX_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			started_q <= 1'b0;
			cnt_q     <= '0;
			sr_q      <= '0;
			en_q      <= 1'b0;
			rdy_q     <= 1'b0;
			dly_q     <= '0;
		end
		else
		begin
			started_q <= started_d;
			cnt_q     <= cnt_d;
			sr_q      <= sr_d;
			en_q      <= en_d;
			rdy_q     <= rdy_d;
			dly_q     <= dly_d;
		end
	end

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			st_q  <= eeprom_pkg::EX_IDLE;
			idx_q <= '0;
			tmr_q <= '0;
		end
		else
		begin
			st_q  <= st_d;
			idx_q <= idx_d;
			tmr_q <= tmr_d;
		end
	end

	// command latched once at launch; clock may stop afterwards
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			lo_q  <= '0;
			hi_q  <= '0;
			cyc_q <= '0;
		end
		else if (launch)
		begin
			lo_q  <= first_ix;
			hi_q  <= last_ix;
			cyc_q <= '{value: value_in, word: word};
		end
	end

	// as-shipped contents; array is not touched by reset
	initial
	begin
		for (int i = 0; i < NBYTES; i++)
			mem[i] = eeprom_pkg::ERASED_BYTE;
	end

	// plain always: the initial block above also writes the array
	always @(posedge CLK)
	begin
		if (st_q == eeprom_pkg::EX_ERASE)
			mem[idx_q] <= eeprom_pkg::ERASED_BYTE;
		else if (st_q == eeprom_pkg::EX_PROG)
			mem[idx_q] <= prog_byte;
	end

	// status on the data output; silent while an instruction shifts in
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			SDO    <= 1'b0;
			SDO_OE <= 1'b0;
		end
		else
		begin
			SDO    <= ~busy;
			SDO_OE <= stat_ok & (busy | rdy_d);
		end
	end
endmodule
`default_nettype wire

// *** eeprom_status_sva.sv ***
// Purpose: status pin checks for the program/erase control
// Assumes: pin synchronisers add two to three CLK of lag
// Notes:   bound to every instance of the top module
`timescale 1ns/100ps
`default_nettype none
module eeprom_status_sva (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic CS,
	input wire logic SCLK,
	input wire logic SDI,
	input wire logic WORD_SIZE_SELECT,
	input wire logic SDO,
	input wire logic SDO_OE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	logic [10:0] busy_q;
	logic [10:0] busy_d;
	wire         busy = SDO_OE && !SDO;
	wire         ready = SDO_OE && SDO;
	assign busy_d = busy ? busy_q + 11'h001 : 11'h000;
	always_ff @(posedge CLK or negedge NRST)
		if (!NRST)
			busy_q <= 11'h000;
		else
			busy_q <= busy_d;
	a_oe_waits: assert property ($rose(SDO_OE) |-> CS && $past(CS, 40))
		else $error("status driven too soon after select");
	a_oe_drops: assert property ($fell(CS) |-> ##[1:6] !SDO_OE)
		else $error("status still driven after deselect");
	a_oe_idle: assert property (!CS [*8] |-> !SDO_OE)
		else $error("status driven while deselected");
	a_oe_late: assert property (SDO_OE |-> $past(CS, 6))
		else $error("status driven without select");
	a_ready_stays: assert property ((ready && CS && !SCLK && !$past(SCLK)
		&& !$past(SCLK, 2) && !$past(SCLK, 3)) |=> SDO)
		else $error("ready level lost without start bit");
	a_ready_no_busy: assert property (ready && CS |=> !busy)
		else $error("busy after ready without instruction");
	a_busy_bound: assert property (busy_q <= 11'h44C)
		else $error("self-timed cycle never ends");
	a_status_kept: assert property ($past(busy) && $past(CS, 5) && CS
		|-> SDO_OE)
		else $error("status dropped while selected");
	cover property (busy);
	cover property (ready);
	cover property (busy ##1 ready);
endmodule
bind serial_eeprom_program_erase_ctrl eeprom_status_sva i_sva (
	.CLK(CLK), .NRST(NRST), .CS(CS), .SCLK(SCLK), .SDI(SDI),
	.WORD_SIZE_SELECT(WORD_SIZE_SELECT), .SDO(SDO), .SDO_OE(SDO_OE));
`default_nettype wire

// *** serial_master.sv ***
// Purpose: bus master model driving the three-wire link
// Assumes: 64 ns serial clock, still between frames
// Notes:   released data line shows the inverse of its last bit
`timescale 1ns/100ps
`default_nettype none
module serial_master (
	output var logic CS,
	output var logic SCLK,
	output var logic SDI
);
	initial
	begin
		CS = 1'b0;
		SCLK = 1'b0;
		SDI = 1'b0;
	end
	task automatic sel(input logic v);
		CS = v;
	endtask
	// bits go out msb first; n counts every pulse
	task automatic frame(input logic [31:0] bits, input int n);
		CS = 1'b1;
		for (int i = n - 1; i >= 0; i--)
		begin
			SDI = bits[i];
			#32;
			SCLK = 1'b1;
			#32;
			SCLK = 1'b0;
		end
		#8;
		CS = 1'b0;
		SDI = ~SDI;
		#40;
	endtask
endmodule
`default_nettype wire

// *** serial_eeprom_program_erase_ctrl_bench.sv ***
// Purpose: self-checking bench for the program/erase control
// Assumes: status pin and the array, read by hierarchy, are the results checked
// Notes:   model tracks enable state and expected array contents
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_program_erase_ctrl_bench;
	localparam int AW = 9;
	localparam int NB = 2 ** AW;
	logic [7:0] model [NB];
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic word_sel = 1'b0;
	logic cs;
	logic sclk;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	int   err_count = 0;
	int   total_checks = 0;
	int   seed = 32'h1379;
	bit   en = 1'b0;
	always #2.5 clk = ~clk;
	serial_master i_master (.CS(cs), .SCLK(sclk), .SDI(sdi));
	serial_eeprom_program_erase_ctrl #(.ADDR_W(AW)) i_dut (
		.CLK(clk), .NRST(nrst), .CS(cs), .SCLK(sclk), .SDI(sdi),
		.WORD_SIZE_SELECT(word_sel), .SDO(sdo), .SDO_OE(sdo_oe));
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chk_byte(input int k, input logic [7:0] exp,
		input logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] mem[%0d] expected %h seen %h", k, exp, got);
		end
	endtask
	task automatic status(input bit launched);
		int i;
		@(posedge clk);
		#1 i_master.sel(1'b1);
		repeat (60) @(posedge clk);
		#1 chk("status enable", launched, sdo_oe);
		if (launched)
		begin
			chk("busy level", 1'b0, sdo);
			i = 0;
			while (sdo !== 1'b1 && i < 1200)
			begin
				@(posedge clk);
				#1 i++;
			end
			chk("ready level", 1'b1, sdo);
			if (i >= 1200)
				final_report;
			repeat (20) @(posedge clk);
			#1 chk("ready held", 1'b1, sdo);
		end
		i_master.sel(1'b0);
		repeat (10) @(posedge clk);
		#1;
	endtask
	// dx adds or drops pulses; hold sends a frame while busy
	task automatic run(input logic [1:0] op, input logic [1:0] lead,
		input int dx, input bit hold);
		int          aw;
		int          dw;
		logic [31:0] adr;
		logic [31:0] bits;
		bit          mod;
		logic [31:0] dat;
		int          lo;
		int          hi;
		aw = word_sel ? AW - 1 : AW;
		mod = op == eeprom_pkg::OP_WRITE || op == eeprom_pkg::OP_ERASE ||
			(op == eeprom_pkg::OP_EXT && lead inside
			{eeprom_pkg::EXT_WRITE_WHOLE_ARRAY, eeprom_pkg::EXT_ERASE_WHOLE_ARRAY});
		dw = (op == eeprom_pkg::OP_WRITE || (op == eeprom_pkg::OP_EXT &&
			lead == eeprom_pkg::EXT_WRITE_WHOLE_ARRAY)) ? (word_sel ? 16 : 8) : 0;
		adr = $random(seed);
		if (op == eeprom_pkg::OP_EXT)
			adr[aw-1 -: 2] = lead;
		adr = adr & ((32'h1 << aw) - 1);
		dat = $random(seed) & ((32'h1 << dw) - 1);
		bits = {29'h00000001, op} << aw | adr;
		bits = bits << dw | dat;
		bits = dx >= 0 ? bits << dx : bits >> -dx;
		i_master.frame(bits, 3 + aw + dw + dx);
		if (hold)
			i_master.frame(32'h00000800, 12);
		status(mod && en && dx == 0);
		// word mode: even byte takes the low half, odd byte the high half
		if (mod && en && dx == 0)
		begin
			lo = op == eeprom_pkg::OP_EXT ? 0 : (word_sel ? 2 * adr : adr);
			hi = op == eeprom_pkg::OP_EXT ? NB - 1
				: (word_sel ? lo + 1 : lo);
			for (int k = lo; k <= hi; k++)
				model[k] = dw == 0 ? 8'hFF
					: ((word_sel && k[0]) ? dat[15:8] : dat[7:0]);
		end
		for (int k = 0; k < NB; k++)
			chk_byte(k, model[k], i_dut.mem[k]);
		if (op == eeprom_pkg::OP_EXT && dx == 0 && !mod)
			en = lead == eeprom_pkg::EXT_EN;
	endtask
	initial
	begin
		for (int k = 0; k < NB; k++)
			model[k] = 8'hFF;
		repeat (2) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (5) @(posedge clk);
		#1;
		run(eeprom_pkg::OP_WRITE, 2'h0, 0, 1'b0);
		run(eeprom_pkg::OP_EXT, eeprom_pkg::EXT_EN, 0, 1'b0);
		run(eeprom_pkg::OP_WRITE, 2'h0, 0, 1'b1);
		run(eeprom_pkg::OP_WRITE, 2'h0, 1, 1'b0);
		run(eeprom_pkg::OP_WRITE, 2'h0, -1, 1'b0);
		run(eeprom_pkg::OP_ERASE, 2'h0, 0, 1'b0);
		run(eeprom_pkg::OP_ERASE, 2'h0, 1, 1'b0);
		run(eeprom_pkg::OP_EXT, eeprom_pkg::EXT_ERASE_WHOLE_ARRAY, 0, 1'b0);
		run(eeprom_pkg::OP_EXT, eeprom_pkg::EXT_WRITE_WHOLE_ARRAY, 0, 1'b0);
		run(eeprom_pkg::OP_EXT, eeprom_pkg::EXT_WRITE_WHOLE_ARRAY, -1, 1'b0);
		run(eeprom_pkg::OP_READ, 2'h0, 0, 1'b0);
		word_sel = 1'b1;
		run(eeprom_pkg::OP_WRITE, 2'h0, 0, 1'b0);
		run(eeprom_pkg::OP_WRITE, 2'h0, -7, 1'b0);
		run(eeprom_pkg::OP_ERASE, 2'h0, 0, 1'b0);
		run(eeprom_pkg::OP_EXT, eeprom_pkg::EXT_WRITE_WHOLE_ARRAY, 0, 1'b0);
		word_sel = 1'b0;
		run(eeprom_pkg::OP_EXT, eeprom_pkg::EXT_DIS, 0, 1'b0);
		run(eeprom_pkg::OP_WRITE, 2'h0, 0, 1'b0);
		final_report;
	end
endmodule
`default_nettype wire
